// File: adp_defines.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  record-path decimation block. Assumes inclusion by bare name from the
  design files; definitions only.
*/
`ifndef ADP_DEFINES_SVH
`define ADP_DEFINES_SVH

// Byte offsets on the register bus
`define ADP_OFS_CTRL    12'h000
`define ADP_OFS_STATUS  12'h004
`define ADP_OFS_LEFT    12'h008
`define ADP_OFS_RIGHT   12'h00C
// Phase delay register index; byte address is four times this
`define ADP_IDX_PHASE   10'h055

// Control register field positions
`define ADP_CTRL_PRB_LO   0
`define ADP_CTRL_PRB_HI   4
`define ADP_CTRL_AOSR64   5
`define ADP_CTRL_DMIC_L   6
`define ADP_CTRL_DMIC_R   7
`define ADP_CTRL_SRC_LO   8
`define ADP_CTRL_SRC_HI   9
`define ADP_CTRL_MCLK_GP  10
`define ADP_CTRL_MCLK_MI  11
`define ADP_CTRL_WL_LO    12
`define ADP_CTRL_WL_HI    13
`define ADP_CTRL_APD      14
`define ADP_CTRL_RUN      15
`define ADP_CTRL_MASK     32'h0000FFFF

// Reset values
`define ADP_CTRL_RST    32'h00000001
`define ADP_PHASE_RST   8'h00

// Oversampling ratios
`define ADP_ADC_OVERSAMPLING_RATIO_128    8'h80
`define ADP_ADC_OVERSAMPLING_RATIO_64     8'h40
`define ADP_ADC_OVERSAMPLING_RATIO_32     8'h20

// Processing block bounds of the filter groups
`define ADP_PRB_B_FIRST 5'h07
`define ADP_PRB_C_FIRST 5'h0D
`define ADP_PRB_LAST    5'h12

// Modulator clock half period, in bus clock cycles
`define ADP_MCLK_HALF   8'h04

`endif

// File: adp_pkg.sv
/*
  Types shared by the decimation block: filter kind, stereo word pair.
  Assumes nothing of its surroundings.
*/
package adp_pkg;

  typedef enum logic [1:0] {
    ADP_FILT_A,
    ADP_FILT_B,
    ADP_FILT_C
  } adp_filt_t;

  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
  } adp_pair_t;

endpackage

// File: adp_bit_delay.sv
/*
  Programmable delay line for a one-bit modulator stream, 0 to 127 samples.
  Assumes smp pulses once per modulator sample.
*/
`timescale 1ns/1ps
module adp_bit_delay (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Stream
  input  wire logic       smp,
  input  wire logic       bit_i,
  input  wire logic [6:0] sel,
  output logic            bit_o
);
  logic [126:0] sr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_q <= '0;
    end else if (smp) begin
      sr_q <= {sr_q[125:0], bit_i};
    end
  end

  // Zero selects the live bit so that no delay costs no sample
  always_comb begin
    if (sel == 7'h00) begin
      bit_o = bit_i;
    end else begin
      bit_o = sr_q[sel - 7'h01];
    end
  end
endmodule

// File: adp_cic_dec.sv
/*
  Fourth-order comb-integrator decimator for a one-bit stream.
  Assumes smp marks each input sample and dec each output sample.
*/
`timescale 1ns/1ps
module adp_cic_dec (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  // Input stream
  input  wire logic        smp,
  input  wire logic        bit_i,
  input  wire logic        dec,
  // Decimated output
  output logic [31:0]      data_q,
  output logic             valid_q
);
  logic [31:0] integ_q [4];
  logic [31:0] dly_q   [4];
  logic [31:0] comb    [5];

  // Modular arithmetic: wrap in the integrators cancels in the combs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        integ_q[i] <= '0;
      end
    end else if (clr) begin
      for (int i = 0; i < 4; i++) begin
        integ_q[i] <= '0;
      end
    end else if (smp) begin
      integ_q[0] <= integ_q[0] + (bit_i ? 32'h00000001 : 32'hFFFFFFFF);
      for (int i = 1; i < 4; i++) begin
        integ_q[i] <= integ_q[i] + integ_q[i-1];
      end
    end
  end

  always_comb begin
    comb[0] = integ_q[3];
    for (int i = 0; i < 4; i++) begin
      comb[i+1] = comb[i] - dly_q[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        dly_q[i] <= '0;
      end
      data_q  <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= dec & ~clr;
      if (clr) begin
        for (int i = 0; i < 4; i++) begin
          dly_q[i] <= '0;
        end
      end else if (dec) begin
        for (int i = 0; i < 4; i++) begin
          dly_q[i] <= comb[i];
        end
        data_q <= comb[4];
      end
    end
  end
endmodule

// File: adp_dec_top.sv
/*
  Record-path back end: modulator clock out, digital microphone capture,
  phase delay, decimation filters A/B/C and stereo word hand-off, with an
  AHB-Lite register slave. Assumes a single clock hclk, inputs synchronous
  to it, and one bus master with this slave alone on the bus.
*/
// Overview of operation
// RULE1: Filter A: up to 48 kHz, ratio 128/64
// RULE2: Software should pick ratio 128 with A
// RULE3: Filter A also runs 96 kHz at 64
// RULE4: Filter B: up to 96 kHz, ratio 64
// RULE5: Filter C: ratio 32, for 192 ksps
// RULE6: Filter C passes up to 0.11 fs
// RULE7: Filter C attenuates 0.28 to 16 fs
// RULE8: One left, one right word per period
// RULE9: Round words down to configured length
// RULE10: Modulator clock out on GPIO or MISO
// RULE11: Microphone returns bits on GPIO/DIN/SCLK
// RULE12: Left on rising, right on falling edge
// RULE13: Microphone enable per left, right, both
// RULE14: Analog section bypassed, may power down
// RULE15: Software sets ratio to suit microphone
// RULE16: Eight-bit phase delay register, index 0x55
// RULE17: Right and left delays from formula
// RULE18: Filter follows the processing block choice
// RULE19: Comb-integrator then linear-phase FIR decimation
// RULE20: Left and right words leave together
`timescale 1ns/1ps
`include "adp_defines.svh"
module adp_dec_top (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Analog modulator bits
  input  wire logic              adc_mod_l,
  input  wire logic              adc_mod_r,
  // Microphone data pins
  input  wire logic              gpio_i,
  input  wire logic              din_i,
  input  wire logic              sclk_i,
  // Modulator clock pins
  output logic                   gpio_o,
  output logic                   gpio_oe,
  output logic                   miso_o,
  output logic                   miso_oe,
  // Analog power down
  output logic                   adc_pd_l,
  output logic                   adc_pd_r,
  // Serial interface hand-off
  output adp_pkg::adp_pair_t     pair,
  output logic                   pair_valid,
  output logic [1:0]             word_len
);
  import adp_pkg::*;

  logic [31:0] ctrl_q;
  logic [7:0]  phase_q;
  logic [15:0] pair_cnt_q;

  // Bus data phase state
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] hrdata_q;

  // Modulator clock and sample timing
  logic [7:0]  half_cnt_q;
  logic        mclk_q;
  logic        mclk_rise;
  logic        mclk_fall;
  logic [7:0]  smp_cnt_q;
  logic        tick;

  // Captured bits
  logic        cap_l_q;
  logic        cap_r_q;
  logic        bit_l;
  logic        bit_r;
  logic        dly_bit_l;
  logic        dly_bit_r;
  logic        mic_bit;

  // Filter path
  adp_filt_t   filt;
  logic [7:0]  adc_oversampling_ratio;
  logic [7:0]  adc_oversampling_ratio_kf;
  logic [6:0]  dly_r;
  logic [6:0]  dly_l;
  logic        run;
  logic        clr;
  logic [31:0] cic_l;
  logic [31:0] cic_r;
  logic        cic_vld;
  logic        cic_vld_r;
  logic        fir_stb_q;
  logic [31:0] hist_l_q [5];
  logic [31:0] hist_r_q [5];
  logic [4:0]  shift;
  logic [31:0] wl_mask;

  logic        addr_ok;
  logic [11:0] addr_a;
  logic [31:0] rd_val;

  assign run = ctrl_q[`ADP_CTRL_RUN];
  assign clr = ~run;

  // Filter kind comes from the processing block only
  always_comb begin
    if (ctrl_q[`ADP_CTRL_PRB_HI:`ADP_CTRL_PRB_LO] >= `ADP_PRB_C_FIRST &&
        ctrl_q[`ADP_CTRL_PRB_HI:`ADP_CTRL_PRB_LO] <= `ADP_PRB_LAST) begin
      filt = ADP_FILT_C; // RULE18
    end else if (ctrl_q[`ADP_CTRL_PRB_HI:`ADP_CTRL_PRB_LO] >= `ADP_PRB_B_FIRST &&
                 ctrl_q[`ADP_CTRL_PRB_HI:`ADP_CTRL_PRB_LO] < `ADP_PRB_C_FIRST) begin
      filt = ADP_FILT_B;
    end else begin
      filt = ADP_FILT_A;
    end
  end

  // Ratio is forced where the filter admits only one value
  always_comb begin
    case (filt)
      ADP_FILT_A: begin
        adc_oversampling_ratio    = ctrl_q[`ADP_CTRL_AOSR64] ? `ADP_ADC_OVERSAMPLING_RATIO_64 : `ADP_ADC_OVERSAMPLING_RATIO_128; // RULE1 RULE3 RULE15
        adc_oversampling_ratio_kf = {2'b00, adc_oversampling_ratio[7:2]};
        shift   = ctrl_q[`ADP_CTRL_AOSR64] ? 5'h06 : 5'h02;
      end
      ADP_FILT_B: begin
        adc_oversampling_ratio    = `ADP_ADC_OVERSAMPLING_RATIO_64; // RULE4
        adc_oversampling_ratio_kf = {1'b0, adc_oversampling_ratio[7:1]};
        shift   = 5'h06;
      end
      ADP_FILT_C: begin
        adc_oversampling_ratio    = `ADP_ADC_OVERSAMPLING_RATIO_32; // RULE5
        adc_oversampling_ratio_kf = adc_oversampling_ratio;
        shift   = 5'h0A;
      end
      default: begin
        adc_oversampling_ratio    = `ADP_ADC_OVERSAMPLING_RATIO_128;
        adc_oversampling_ratio_kf = {2'b00, adc_oversampling_ratio[7:2]};
        shift   = 5'h02;
      end
    endcase
  end

  // Delays counted in modulator samples, 1/(ratio*fs) each
  assign dly_r = {2'b00, phase_q[4:0]} + 7'(phase_q[6:5] * adc_oversampling_ratio_kf); // RULE17
  assign dly_l = {6'h00, phase_q[7]}; // RULE17

  // Modulator clock divided from the bus clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_cnt_q <= '0;
      mclk_q     <= 1'b0;
    end else if (clr) begin
      half_cnt_q <= '0;
      mclk_q     <= 1'b0;
    end else if (half_cnt_q == `ADP_MCLK_HALF - 8'h01) begin
      half_cnt_q <= '0;
      mclk_q     <= ~mclk_q;
    end else begin
      half_cnt_q <= half_cnt_q + 8'h01;
    end
  end

  assign mclk_rise = run & (half_cnt_q == `ADP_MCLK_HALF - 8'h01) & ~mclk_q;
  assign mclk_fall = run & (half_cnt_q == `ADP_MCLK_HALF - 8'h01) & mclk_q;

  // Pin drives the clock only while enabled; idle low otherwise
  assign gpio_o  = ctrl_q[`ADP_CTRL_MCLK_GP] & mclk_q; // RULE10
  assign gpio_oe = ctrl_q[`ADP_CTRL_MCLK_GP]; // RULE10
  assign miso_o  = ctrl_q[`ADP_CTRL_MCLK_MI] & mclk_q; // RULE10
  assign miso_oe = ctrl_q[`ADP_CTRL_MCLK_MI]; // RULE10

  // Data may share GPIO only if the clock is not driven there
  always_comb begin
    case (ctrl_q[`ADP_CTRL_SRC_HI:`ADP_CTRL_SRC_LO])
      2'h0:    mic_bit = gpio_i; // RULE11
      2'h1:    mic_bit = din_i;
      2'h2:    mic_bit = sclk_i;
      default: mic_bit = din_i;
    endcase
  end

  // Sampled just before the edge leaves, so the level is the settled one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_l_q <= 1'b0;
      cap_r_q <= 1'b0;
    end else begin
      if (mclk_rise) begin
        cap_l_q <= mic_bit; // RULE12
      end
      if (mclk_fall) begin
        cap_r_q <= mic_bit; // RULE12
      end
    end
  end

  // Per channel choice of microphone or analog modulator
  assign bit_l = ctrl_q[`ADP_CTRL_DMIC_L] ? cap_l_q : adc_mod_l; // RULE13 RULE14
  assign bit_r = ctrl_q[`ADP_CTRL_DMIC_R] ? cap_r_q : adc_mod_r; // RULE13 RULE14
  assign adc_pd_l = ctrl_q[`ADP_CTRL_DMIC_L] & ctrl_q[`ADP_CTRL_APD]; // RULE14
  assign adc_pd_r = ctrl_q[`ADP_CTRL_DMIC_R] & ctrl_q[`ADP_CTRL_APD]; // RULE14

  // One shared sample tick keeps both channels in step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp_cnt_q <= '0;
    end else if (clr) begin
      smp_cnt_q <= '0;
    end else if (mclk_rise) begin
      smp_cnt_q <= (smp_cnt_q >= adc_oversampling_ratio - 8'h01) ? 8'h00 : smp_cnt_q + 8'h01;
    end
  end

  assign tick = mclk_rise & (smp_cnt_q >= adc_oversampling_ratio - 8'h01); // RULE19 RULE20

  // Both channels shift on the rising edge; right data already held from fall
  adp_bit_delay u_dly_l (
    .clk   (hclk),
    .rst_n (hresetn),
    .smp   (mclk_rise),
    .bit_i (bit_l),
    .sel   (dly_l),
    .bit_o (dly_bit_l)
  );

  adp_bit_delay u_dly_r (
    .clk   (hclk),
    .rst_n (hresetn),
    .smp   (mclk_rise),
    .bit_i (bit_r),
    .sel   (dly_r),
    .bit_o (dly_bit_r)
  );

  adp_cic_dec u_cic_l (
    .clk     (hclk),
    .rst_n   (hresetn),
    .clr     (clr),
    .smp     (mclk_rise),
    .bit_i   (dly_bit_l),
    .dec     (tick),
    .data_q  (cic_l),
    .valid_q (cic_vld)
  );

  adp_cic_dec u_cic_r (
    .clk     (hclk),
    .rst_n   (hresetn),
    .clr     (clr),
    .smp     (mclk_rise),
    .bit_i   (dly_bit_r),
    .dec     (tick),
    .data_q  (cic_r),
    .valid_q (cic_vld_r)
  );

  // Binomial taps stay symmetric, so the FIR adds no phase distortion
  function automatic logic [31:0] fir(input adp_filt_t f,
                                      input logic [31:0] h0, input logic [31:0] h1,
                                      input logic [31:0] h2, input logic [31:0] h3,
                                      input logic [31:0] h4);
    logic signed [35:0] acc;
    acc = '0;
    case (f)
      ADP_FILT_A: begin
        acc = 36'(signed'(h0)) + 36'(signed'(h1)) * 36'sh4 + 36'(signed'(h2)) * 36'sh6
            + 36'(signed'(h3)) * 36'sh4 + 36'(signed'(h4));
        acc = acc >>> 4;
      end
      ADP_FILT_B: begin
        acc = 36'(signed'(h0)) + 36'(signed'(h1)) * 36'sh2 + 36'(signed'(h2));
        acc = acc >>> 2;
      end
      ADP_FILT_C: begin
        // Short kernel keeps the pass band out to 0.11 fs
        acc = 36'(signed'(h0)) + 36'(signed'(h1)) * 36'sh2 + 36'(signed'(h2)); // RULE6 RULE7
        acc = acc >>> 2;
      end
      default: begin
        acc = 36'(signed'(h0));
      end
    endcase
    return acc[31:0];
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 5; i++) begin
        hist_l_q[i] <= '0;
        hist_r_q[i] <= '0;
      end
      fir_stb_q <= 1'b0;
    end else begin
      fir_stb_q <= cic_vld & cic_vld_r;
      if (clr) begin
        for (int i = 0; i < 5; i++) begin
          hist_l_q[i] <= '0;
          hist_r_q[i] <= '0;
        end
      end else if (cic_vld & cic_vld_r) begin
        hist_l_q[0] <= cic_l; // RULE19
        hist_r_q[0] <= cic_r;
        for (int i = 1; i < 5; i++) begin
          hist_l_q[i] <= hist_l_q[i-1];
          hist_r_q[i] <= hist_r_q[i-1];
        end
      end
    end
  end

  // Truncation toward minus infinity: low bits dropped
  always_comb begin
    case (ctrl_q[`ADP_CTRL_WL_HI:`ADP_CTRL_WL_LO])
      2'h0:    wl_mask = 32'hFFFF0000;
      2'h1:    wl_mask = 32'hFFFFF000;
      2'h2:    wl_mask = 32'hFFFFFF00;
      default: wl_mask = 32'hFFFFFFFF;
    endcase
  end

  assign word_len = ctrl_q[`ADP_CTRL_WL_HI:`ADP_CTRL_WL_LO];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pair       <= '0;
      pair_valid <= 1'b0;
      pair_cnt_q <= '0;
    end else begin
      pair_valid <= fir_stb_q & run; // RULE8 RULE20
      if (fir_stb_q & run) begin
        pair.left  <= (fir(filt, hist_l_q[0], hist_l_q[1], hist_l_q[2], hist_l_q[3],
                           hist_l_q[4]) << shift) & wl_mask; // RULE8 RULE9
        pair.right <= (fir(filt, hist_r_q[0], hist_r_q[1], hist_r_q[2], hist_r_q[3],
                           hist_r_q[4]) << shift) & wl_mask; // RULE8 RULE9
        pair_cnt_q <= pair_cnt_q + 16'h0001;
      end
    end
  end

  // Zero wait states; every response OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign addr_ok   = hsel & hready & htrans[1];
  assign addr_a    = haddr[11:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      // Only whole-word writes are honoured
      wr_pend_q <= addr_ok & hwrite & (hsize == 3'h2);
      wr_addr_q <= addr_a;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= `ADP_CTRL_RST;
      phase_q <= `ADP_PHASE_RST;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `ADP_OFS_CTRL) begin
        ctrl_q <= hwdata & `ADP_CTRL_MASK;
      end
      if (wr_addr_q == {`ADP_IDX_PHASE, 2'b00}) begin
        phase_q <= hwdata[7:0]; // RULE16
      end
    end
  end

  // A read right behind a write to the same word sees the new value
  always_comb begin
    case (addr_a)
      `ADP_OFS_CTRL:   rd_val = ctrl_q;
      `ADP_OFS_STATUS: rd_val = {6'h00, adc_oversampling_ratio, filt, pair_cnt_q};
      `ADP_OFS_LEFT:   rd_val = pair.left;
      `ADP_OFS_RIGHT:  rd_val = pair.right;
      {`ADP_IDX_PHASE, 2'b00}: rd_val = {24'h000000, phase_q};
      default:         rd_val = 32'h00000000;
    endcase
    if (wr_pend_q && wr_addr_q == addr_a) begin
      if (addr_a == `ADP_OFS_CTRL) begin
        rd_val = hwdata & `ADP_CTRL_MASK;
      end else if (addr_a == {`ADP_IDX_PHASE, 2'b00}) begin
        rd_val = {24'h000000, hwdata[7:0]};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (addr_ok & ~hwrite) begin
      hrdata_q <= rd_val;
    end
  end

endmodule

// File: adp_dec_sva.sv
/*
  Port checker of the record-path decimation block.
  Assumes it is bound to adp_dec_top, with one clock hclk.
*/
`timescale 1ns/1ps
module adp_dec_sva (
  // Clock and reset
  input wire logic               hclk,
  input wire logic               hresetn,
  // Bus
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  // Pins and hand-off
  input wire logic               gpio_o,
  input wire logic               gpio_oe,
  input wire logic               miso_o,
  input wire logic               miso_oe,
  input wire adp_pkg::adp_pair_t pair,
  input wire logic               pair_valid,
  input wire logic [1:0]         word_len
);
  import adp_pkg::*;
  logic [31:0] low_mask;
  // Bits below the configured word length
  assign low_mask = (word_len == 2'h3) ? 32'h0 : (32'h0000FFFF >> {word_len, 2'b00});
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or errored");
  a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_valid_pulse: assert property (pair_valid |=> !pair_valid [*8])
    else $error("pair strobe too long or too close");
  a_pair_hold: assert property ($changed(pair) |-> pair_valid)
    else $error("pair changed without strobe");
  a_word_round: assert property (pair_valid |-> ((pair.left | pair.right) & low_mask) == 32'h0)
    else $error("pair word not rounded to word length");
  a_gpio_quiet: assert property (!gpio_oe |-> !gpio_o)
    else $error("gpio driven high while disabled");
  a_miso_quiet: assert property (!miso_oe |-> !miso_o)
    else $error("miso driven high while disabled");
  a_clk_high: assert property ($rose(gpio_o) |=> (gpio_o || !gpio_oe) [*3] ##1 !gpio_o)
    else $error("modulator clock high phase wrong");
  a_pins_agree: assert property (gpio_oe && miso_oe |-> gpio_o == miso_o)
    else $error("clock pins disagree");
endmodule

bind adp_dec_top adp_dec_sva u_adp_dec_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .gpio_o, .gpio_oe, .miso_o, .miso_oe, .pair, .pair_valid,
  .word_len);

// File: adp_mic_model.sv
/*
  Behavioural one-bit digital microphone.
  Assumes its clock input is the modulator clock seen on the pins.
*/
`timescale 1ns/1ps
module adp_mic_model (
  // Clock
  input wire logic hclk,
  // Microphone side
  input wire logic mic_clk,
  input wire logic left_lvl,
  input wire logic right_lvl,
  output logic     mic_dat
);
  logic [1:0] seen_q;
  logic [3:0] idle_q;
  initial begin
    seen_q = 2'h0;
    idle_q = 4'h0;
    mic_dat = 1'b0;
  end
  // Data lags each clock edge by two cycles, so it is steady around the next edge
  always @(posedge hclk) begin
    seen_q <= {seen_q[0], mic_clk};
    idle_q <= (mic_clk != seen_q[0]) ? 4'h0 : ((idle_q == 4'hF) ? idle_q : idle_q + 4'h1);
    if (seen_q[1] != seen_q[0]) begin
      mic_dat <= seen_q[0] ? right_lvl : left_lvl;
    end else if (idle_q == 4'hF) begin
      // Released line: no stale level while the clock stands
      mic_dat <= ~mic_dat;
    end
  end
endmodule

// File: tb_adc_decimation_dmic_phase.sv
/*
  Self-checking bench of the decimation block: registers, filter choice,
  microphone capture and pair timing. Assumes package, defines, design,
  checker and microphone model compiled before it.
*/
`timescale 1ns/1ps
`include "adp_defines.svh"
module tb_adc_decimation_dmic_phase;
  import adp_pkg::*;
  localparam logic [11:0] PH = {`ADP_IDX_PHASE, 2'b00};
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv, v;
  logic [1:0]  htrans, word_len, src;
  logic [2:0]  hsize;
  logic        adc_mod_l, adc_mod_r, gpio_i, din_i, sclk_i, gpio_o, gpio_oe, miso_o, miso_oe;
  logic        adc_pd_l, adc_pd_r, pair_valid, mic_l, mic_r, mic_dat;
  adp_pair_t   pair;
  logic [15:0] lf;
  logic [4:0]  pl [6] = '{5'h01, 5'h06, 5'h07, 5'h0C, 5'h0D, 5'h12};
  int          err_total, compares, cyc, npv;

  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;

  adp_dec_top u_adp_dec_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .adc_mod_l, .adc_mod_r, .gpio_i, .din_i, .sclk_i,
    .gpio_o, .gpio_oe, .miso_o, .miso_oe, .adc_pd_l, .adc_pd_r, .pair, .pair_valid, .word_len);
  adp_mic_model u_adp_mic_model (.hclk, .mic_clk((gpio_oe & gpio_o) | (miso_oe & miso_o)),
    .left_lvl(mic_l), .right_lvl(mic_r), .mic_dat(mic_dat));
  // Microphone on the selected pin, noise on the others so a wrong pick shows
  assign gpio_i = (src == 2'h0) ? mic_dat : lf[9];
  assign din_i  = (src == 2'h1 || src == 2'h3) ? mic_dat : lf[3];
  assign sclk_i = (src == 2'h2) ? mic_dat : lf[12];

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] exp_status(input logic [4:0] prb, input logic r64);
    logic [1:0] f;
    logic [7:0] r;
    f = (prb >= `ADP_PRB_C_FIRST && prb <= `ADP_PRB_LAST) ? 2'h2 :
        (prb >= `ADP_PRB_B_FIRST && prb < `ADP_PRB_C_FIRST) ? 2'h1 : 2'h0;
    r = (f == 2'h2) ? `ADP_ADC_OVERSAMPLING_RATIO_32 : ((f == 2'h1 || r64) ? `ADP_ADC_OVERSAMPLING_RATIO_64 : `ADP_ADC_OVERSAMPLING_RATIO_128);
    return {6'h0, r, f, 16'h0};
  endfunction

  always @(posedge hclk) begin
    lf <= lfsr_next(lf);
    adc_mod_l <= lf[0];
    adc_mod_r <= lf[5];
    cyc <= cyc + 1;
    if (pair_valid === 1'b1) npv <= npv + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [2:0] s);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= s;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rdv = hrdata;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 3'h2);
    chk(nm, e, rdv);
  endtask

  task automatic wait_pv;
    int n;
    n = 0;
    @(posedge hclk);
    while (pair_valid !== 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 3000) chk("pair_valid", 32'h1, 32'h0);
  endtask

  task automatic run_case(input logic [4:0] prb, input logic r64, dl, dr, ml, mr, gp,
                          input logic [1:0] s);
    logic [31:0] ctl;
    logic [31:0] st;
    int          t0;
    // Clock always on the second pin too, so both pins run together at times
    ctl = {16'h0, 2'h3, lf[1:0], 1'b1, gp, s, dr, dl, r64, prb};
    st = exp_status(prb, r64);
    mic_l <= ml;
    mic_r <= mr;
    src <= s;
    bus(1'b1, PH, {16'h0, lf}, 3'h2);
    bus(1'b1, `ADP_OFS_CTRL, ctl, 3'h2);
    @(posedge hclk);
    chk("gpio_oe", gp, gpio_oe);
    chk("miso_oe", 1'b1, miso_oe);
    chk("adc_pd_l", dl, adc_pd_l);
    chk("adc_pd_r", dr, adc_pd_r);
    chk("word_len", ctl[13:12], word_len);
    repeat (4) wait_pv();
    t0 = cyc;
    wait_pv();
    chk("period", st[25:18] * 8, cyc - t0);
    chk("left_above", ((dl ? 2 * ml : 1) > (dr ? 2 * mr : 1)),
        $signed(pair.left) > $signed(pair.right));
    bus(1'b0, `ADP_OFS_STATUS, 32'h0, 3'h2);
    chk("status", st | npv, rdv);
    bus(1'b1, `ADP_OFS_CTRL, 32'h0, 3'h2);
    $display("test run block %0d done", prb);
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge hclk);
    err_total++;
    summarize();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    adc_mod_l = 1'b0;
    adc_mod_r = 1'b0;
    src = 2'h1;
    mic_l = 1'b0;
    mic_r = 1'b0;
    lf = 16'h0008;
    err_total = 0;
    compares = 0;
    cyc = 0;
    npv = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("ctrl", `ADP_OFS_CTRL, `ADP_CTRL_RST);
    rchk("phase", PH, {24'h0, `ADP_PHASE_RST});
    bus(1'b1, 12'h200, 32'hFFFFFFFF, 3'h2);
    rchk("unmapped", 12'h200, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = {16'h0, lf} & 32'h00007FFF;
      bus(1'b1, `ADP_OFS_CTRL, v, 3'h2);
      // Narrow write must leave the word alone
      bus(1'b1, `ADP_OFS_CTRL, 32'hFFFFFFFF, 3'h0);
      rchk("ctrl", `ADP_OFS_CTRL, v);
      v = {lf, lf};
      bus(1'b1, PH, v, 3'h2);
      rchk("phase", PH, {24'h0, v[7:0]});
    end
    $display("test registers done");
    foreach (pl[i]) begin
      for (int r = 0; r < 2; r++) begin
        bus(1'b1, `ADP_OFS_CTRL, {26'h0, r[0], pl[i]}, 3'h2);
        bus(1'b1, `ADP_OFS_STATUS, 32'hFFFFFFFF, 3'h2);
        rchk("status", `ADP_OFS_STATUS, exp_status(pl[i], r[0]));
      end
    end
    $display("test filter choice done");
    // Pair count in status is cumulative since reset, so npv is never cleared
    run_case(5'h01, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 2'h1);
    run_case(5'h02, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0);
    run_case(5'h08, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h2);
    run_case(5'h0E, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 2'h3);
    summarize();
  end
endmodule
